/* design/fifo_service_map.vh */
// Offsets, fields, reset values and levels of the FIFO service flags
`ifndef FIFO_SERVICE_MAP_VH
`define FIFO_SERVICE_MAP_VH

// ==========================================================
// Register offsets (byte addresses on the register port)
`define FSR_ADDR_W 8
`define FSR_OFF_RX_FILL 8'h10
`define FSR_OFF_TX_FILL 8'h11
`define FSR_OFF_ISR 8'h25
`define FSR_OFF_MODE_ZERO 8'h30
`define FSR_OFF_MODE_TWO 8'h32
`define FSR_OFF_EVT_STATUS 8'h34
`define FSR_OFF_EVT_MASK 8'h35
`define FSR_OFF_PIN_CFG 8'h36
`define FSR_OFF_RX_LEVEL 8'h46
`define FSR_OFF_TX_LEVEL 8'h47

// ==========================================================
// Field positions
`define FSR_ISR_TX_BIT 0
`define FSR_ISR_RX_BIT 1
`define FSR_MR0_TX_TRIG_LO 4
`define FSR_MR2_RX_TRIG_LO 2
`define FSR_PIN_RX_DMA_BIT 0
`define FSR_PIN_TX_DMA_BIT 1
`define FSR_EVT_TX_RISE 0
`define FSR_EVT_RX_RISE 1
`define FSR_EVT_RX_OVER 2
`define FSR_EVT_TX_OVER 3
`define FSR_EVT_W 4

// ==========================================================
// Reset values
`define FSR_RST_BYTE 8'h00
`define FSR_RST_TRIG 2'h0
`define FSR_RST_EVT 4'h0

// ==========================================================
// Trigger codes and fill thresholds (counts of 0 to 256)
`define FSR_TRIG_CODE_0 2'h0
`define FSR_TRIG_CODE_1 2'h1
`define FSR_TRIG_CODE_2 2'h2
`define FSR_TRIG_CODE_3 2'h3
`define FSR_DEPTH 256
`define FSR_CNT_W 9
`define FSR_LVL_ONE 9'h001
`define FSR_LVL_HALF 9'h080
`define FSR_LVL_THREE_Q 9'h0c0
`define FSR_LVL_FULL 9'h100
`define FSR_LVL_ZERO_BYTE 8'h00

`endif

/* design/occupancy_counter.v */
// Occupancy counter of one 256-entry queue
`timescale 1ns/10ps
module occupancy_counter #(
  parameter DEPTH = 256,
  parameter CNT_W = 9
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  // Queue events
  input wire push_i,
  input wire pop_i,
  // Fill state
  output reg [CNT_W-1:0] count_o,
  output wire full_o,
  output wire empty_o
);

  localparam [CNT_W-1:0] FULL_CNT = DEPTH[CNT_W-1:0];
  localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  wire do_push;
  wire do_pop;

  // A push into a full queue or a pop from an empty one is dropped
  assign full_o = (count_o == FULL_CNT);
  assign empty_o = (count_o == {CNT_W{1'b0}});
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;

  // Count follows every accepted push and pop
  always @(posedge clk_i) begin
    if (srst_i) begin
      count_o <= {CNT_W{1'b0}};
    end else if (ce_i) begin
      if (do_push && !do_pop) begin
        count_o <= count_o + ONE;
      end else if (do_pop && !do_push) begin
        count_o <= count_o - ONE;
      end
    end
  end

endmodule

/* design/fifo_service_request_flags.v */
// Receive and transmit service-request flags of one serial channel
`timescale 1ns/10ps
`include "fifo_service_map.vh"
module fifo_service_request_flags #(
  parameter DEPTH = `FSR_DEPTH,
  parameter CNT_W = `FSR_CNT_W
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // Queue events from the channel datapath
  input wire rx_push_i,
  input wire rx_pop_i,
  input wire tx_push_i,
  input wire tx_pop_i,
  // Service flags and arbitration requests
  output wire receive_service_flag_o,
  output wire transmit_service_flag_o,
  output wire rx_arb_req_o,
  output wire tx_arb_req_o,
  output wire interrupt_request_low_o,
  // DMA handshakes on the I/O pins
  output wire rx_dma_req_o,
  output wire tx_dma_req_o,
  // Event interrupt
  output wire irq_o
);

  // ==========================================================
  // Decoding shared by several thresholds

  // Receive level in entries; the receive flag is fill >= level
  function [CNT_W-1:0] rx_level;
    input [1:0] code;
    begin
      case (code)
        `FSR_TRIG_CODE_0: rx_level = `FSR_LVL_ONE;
        `FSR_TRIG_CODE_1: rx_level = `FSR_LVL_HALF;
        `FSR_TRIG_CODE_2: rx_level = `FSR_LVL_THREE_Q;
        default: rx_level = `FSR_LVL_FULL;
      endcase
    end
  endfunction

  // Transmit level in entries; the transmit flag is fill < level
  function [CNT_W-1:0] tx_level;
    input [1:0] code;
    begin
      case (code)
        `FSR_TRIG_CODE_0: tx_level = `FSR_LVL_ONE;
        `FSR_TRIG_CODE_1: tx_level = `FSR_LVL_HALF;
        `FSR_TRIG_CODE_2: tx_level = `FSR_LVL_THREE_Q;
        default: tx_level = `FSR_LVL_FULL;
      endcase
    end
  endfunction

  // Byte level register: zero stands for 256 entries
  function [CNT_W-1:0] byte_level;
    input [7:0] lvl;
    begin
      if (lvl == `FSR_LVL_ZERO_BYTE) begin
        byte_level = `FSR_LVL_FULL;
      end else begin
        byte_level = {1'b0, lvl};
      end
    end
  endfunction

  // ==========================================================
  // Register state
  reg [7:0] mode_register_zero;
  reg [7:0] mode_register_two;
  reg [7:0] interrupt_mask_bits;
  reg [7:0] receive_trigger_level;
  reg [7:0] transmit_trigger_level;
  reg rx_level_override;
  reg tx_level_override;
  reg [7:0] pin_cfg;
  reg [`FSR_EVT_W-1:0] evt_status;
  reg [`FSR_EVT_W-1:0] evt_mask;
  reg rx_flag_prev;
  reg tx_flag_prev;

  // ==========================================================
  // Queue occupancy
  wire [CNT_W-1:0] rx_count;
  wire [CNT_W-1:0] tx_count;
  wire rx_full;
  wire rx_empty;
  wire tx_full;
  wire tx_empty;

  // Receive queue count, 0 to 256 entries
  occupancy_counter #(
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_rx_count (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .push_i(rx_push_i),
    .pop_i(rx_pop_i),
    .count_o(rx_count),
    .full_o(rx_full),
    .empty_o(rx_empty)
  );

  // Transmit queue count, 0 to 256 entries
  occupancy_counter #(
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_tx_count (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .push_i(tx_push_i),
    .pop_i(tx_pop_i),
    .count_o(tx_count),
    .full_o(tx_full),
    .empty_o(tx_empty)
  );

  // ==========================================================
  // Flag thresholds
  wire [1:0] rx_code;
  wire [1:0] tx_code;
  wire [CNT_W-1:0] rx_thr;
  wire [CNT_W-1:0] tx_thr;
  wire rx_flag;
  wire tx_flag;

  assign rx_code = mode_register_two[`FSR_MR2_RX_TRIG_LO+1:
                                     `FSR_MR2_RX_TRIG_LO];
  assign tx_code = mode_register_zero[`FSR_MR0_TX_TRIG_LO+1:
                                      `FSR_MR0_TX_TRIG_LO];

  // A written level register takes over from the mode code
  assign rx_thr = rx_level_override ? byte_level(receive_trigger_level)
                                    : rx_level(rx_code);
  assign tx_thr = tx_level_override ? byte_level(transmit_trigger_level)
                                    : tx_level(tx_code);

  // Receive flag: level one gives ready, full level needs 256
  // entries, so a held character sets it again on entry
  assign rx_flag = (rx_count >= rx_thr);

  // Transmit flag: code 00 gives level one, i.e. empty only;
  // a full queue is never below any level
  assign tx_flag = (tx_count < tx_thr);

  // ==========================================================
  // Flags, arbitration and pins

  // Flags at source bits 1 and 0
  assign receive_service_flag_o = rx_flag;
  assign transmit_service_flag_o = tx_flag;

  // Only a set flag with its mask bit enters arbitration
  assign rx_arb_req_o = rx_flag &&
                        interrupt_mask_bits[`FSR_ISR_RX_BIT];
  assign tx_arb_req_o = tx_flag &&
                        interrupt_mask_bits[`FSR_ISR_TX_BIT];

  // Request pin is low while either unit arbitrates
  assign interrupt_request_low_o = !(rx_arb_req_o || tx_arb_req_o);

  // DMA handshakes reuse the flags when the pins are assigned
  assign rx_dma_req_o = rx_flag && pin_cfg[`FSR_PIN_RX_DMA_BIT];
  assign tx_dma_req_o = tx_flag && pin_cfg[`FSR_PIN_TX_DMA_BIT];

  // ==========================================================
  // Register writes
  wire wr_isr;
  wire wr_mr0;
  wire wr_mr2;
  wire wr_rx_lvl;
  wire wr_tx_lvl;
  wire wr_pin;
  wire wr_evt;
  wire wr_emask;

  // Offset 0x25 is the source register on read, the mask on write
  assign wr_isr = wr_i && (addr_i == `FSR_OFF_ISR);
  assign wr_mr0 = wr_i && (addr_i == `FSR_OFF_MODE_ZERO);
  assign wr_mr2 = wr_i && (addr_i == `FSR_OFF_MODE_TWO);
  assign wr_rx_lvl = wr_i && (addr_i == `FSR_OFF_RX_LEVEL);
  assign wr_tx_lvl = wr_i && (addr_i == `FSR_OFF_TX_LEVEL);
  assign wr_pin = wr_i && (addr_i == `FSR_OFF_PIN_CFG);
  assign wr_evt = wr_i && (addr_i == `FSR_OFF_EVT_STATUS);
  assign wr_emask = wr_i && (addr_i == `FSR_OFF_EVT_MASK);

  // Control registers; a mode write gives control back to the code
  always @(posedge clk_i) begin
    if (srst_i) begin
      mode_register_zero <= `FSR_RST_BYTE;
      mode_register_two <= `FSR_RST_BYTE;
      interrupt_mask_bits <= `FSR_RST_BYTE;
      receive_trigger_level <= `FSR_RST_BYTE;
      transmit_trigger_level <= `FSR_RST_BYTE;
      rx_level_override <= 1'b0;
      tx_level_override <= 1'b0;
      pin_cfg <= `FSR_RST_BYTE;
      evt_mask <= `FSR_RST_EVT;
    end else if (ce_i) begin
      if (wr_isr) begin
        interrupt_mask_bits <= wdata_i;
      end
      if (wr_mr0) begin
        mode_register_zero <= wdata_i;
        tx_level_override <= 1'b0;
      end
      if (wr_mr2) begin
        mode_register_two <= wdata_i;
        rx_level_override <= 1'b0;
      end
      if (wr_rx_lvl) begin
        receive_trigger_level <= wdata_i;
        rx_level_override <= 1'b1;
      end
      if (wr_tx_lvl) begin
        transmit_trigger_level <= wdata_i;
        tx_level_override <= 1'b1;
      end
      if (wr_pin) begin
        pin_cfg <= wdata_i;
      end
      if (wr_emask) begin
        evt_mask <= wdata_i[`FSR_EVT_W-1:0];
      end
    end
  end

  // ==========================================================
  // Sticky events
  reg [`FSR_EVT_W-1:0] evt_set;
  reg [`FSR_EVT_W-1:0] next_evt_status;

  // Rising flags and pushes dropped with no pop in the same cycle raise events
  always @* begin
    evt_set = `FSR_RST_EVT;
    evt_set[`FSR_EVT_TX_RISE] = tx_flag && !tx_flag_prev;
    evt_set[`FSR_EVT_RX_RISE] = rx_flag && !rx_flag_prev;
    evt_set[`FSR_EVT_RX_OVER] = rx_push_i && rx_full && !rx_pop_i;
    evt_set[`FSR_EVT_TX_OVER] = tx_push_i && tx_full && !tx_pop_i;
  end

  // Write one to clear; a set in the same cycle wins
  always @* begin
    next_evt_status = evt_status;
    if (wr_evt) begin
      next_evt_status = evt_status & ~wdata_i[`FSR_EVT_W-1:0];
    end
    next_evt_status = next_evt_status | evt_set;
  end

  // Previous flags start at their reset levels (receive low, transmit high) so reset itself raises no event
  always @(posedge clk_i) begin
    if (srst_i) begin
      evt_status <= `FSR_RST_EVT;
      rx_flag_prev <= 1'b0;
      tx_flag_prev <= 1'b1;
    end else if (ce_i) begin
      evt_status <= next_evt_status;
      rx_flag_prev <= rx_flag;
      tx_flag_prev <= tx_flag;
    end
  end

  // Level output while any unmasked event is pending
  assign irq_o = |(evt_status & evt_mask);

  // ==========================================================
  // Register reads
  reg [7:0] next_rdata;

  // Unmapped offsets read zero; a 256-entry count reads as 0
  always @* begin
    next_rdata = `FSR_RST_BYTE;
    case (addr_i)
      `FSR_OFF_ISR: begin
        next_rdata[`FSR_ISR_RX_BIT] = rx_flag;
        next_rdata[`FSR_ISR_TX_BIT] = tx_flag;
      end
      `FSR_OFF_RX_FILL: next_rdata = rx_count[7:0];
      `FSR_OFF_TX_FILL: next_rdata = tx_count[7:0];
      `FSR_OFF_MODE_ZERO: next_rdata = mode_register_zero;
      `FSR_OFF_MODE_TWO: next_rdata = mode_register_two;
      `FSR_OFF_RX_LEVEL: next_rdata = receive_trigger_level;
      `FSR_OFF_TX_LEVEL: next_rdata = transmit_trigger_level;
      `FSR_OFF_PIN_CFG: next_rdata = pin_cfg;
      `FSR_OFF_EVT_STATUS: next_rdata = {4'h0, evt_status};
      `FSR_OFF_EVT_MASK: next_rdata = {4'h0, evt_mask};
      default: next_rdata = `FSR_RST_BYTE;
    endcase
  end

  // Read data held only for the cycle after the strobe
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= `FSR_RST_BYTE;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_o <= next_rdata;
      end else begin
        rdata_o <= `FSR_RST_BYTE;
      end
    end
  end

  // Empty flags are kept for future status reads
  wire unused_empty;
  assign unused_empty = rx_empty ^ tx_empty;

endmodule

/* design/fifo_service_request_flags_tail.v */
// Spare unit of the service-flag block; it holds no logic
`timescale 1ns/10ps

/* verification/dma_partner.sv */
// Behavioural DMA controller facing the service-flag handshakes
`timescale 1ns/10ps
module dma_partner (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Controls from the bench
  input wire logic rx_en_i,
  input wire logic tx_en_i,
  input wire logic slow_i,
  // Handshakes from the device
  input wire logic rx_dma_req_i,
  input wire logic tx_dma_req_i,
  // Queue events towards the device
  output logic rx_pop_o,
  output logic tx_push_o
);
  // ==========================================================
  // Pacing
  logic phase;
  // Slow mode acts on every other cycle only
  always @(posedge clk_i) begin
    if (srst_i) begin
      phase <= 1'b0;
    end else begin
      phase <= slow_i ? !phase : 1'b1;
    end
  end
  // Acting in the same cycle as the request avoids overshoot
  assign rx_pop_o = rx_en_i & rx_dma_req_i & phase;
  assign tx_push_o = tx_en_i & tx_dma_req_i & phase;
endmodule

/* verification/fifo_service_checker_assertions.sv */
// Port-level checker of the FIFO service flags
`timescale 1ns/10ps
module fifo_service_checker (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Queue events
  input wire logic rx_push_i,
  input wire logic rx_pop_i,
  input wire logic tx_push_i,
  input wire logic tx_pop_i,
  // Flags and requests
  input wire logic receive_service_flag_o,
  input wire logic transmit_service_flag_o,
  input wire logic rx_arb_req_o,
  input wire logic tx_arb_req_o,
  input wire logic interrupt_request_low_o,
  input wire logic rx_dma_req_o,
  input wire logic tx_dma_req_o,
  input wire logic irq_o
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_RX_ARB: assert property (
    rx_arb_req_o |-> receive_service_flag_o) else $error("rx arb w/o flag");
  AST_TX_ARB: assert property (
    tx_arb_req_o |-> transmit_service_flag_o) else $error("tx arb w/o flag");
  AST_IRQ_LOW: assert property (
    interrupt_request_low_o == !(rx_arb_req_o || tx_arb_req_o))
    else $error("request pin wrong");
  AST_RX_DMA: assert property (
    rx_dma_req_o |-> receive_service_flag_o) else $error("rx dma w/o flag");
  AST_TX_DMA: assert property (
    tx_dma_req_o |-> transmit_service_flag_o) else $error("tx dma w/o flag");
  AST_ISR_READ: assert property (
    ce_i && rd_i && addr_i == 8'h25 |=> rdata_o == {6'h00,
    $past(receive_service_flag_o), $past(transmit_service_flag_o)})
    else $error("source read wrong");
  AST_RDATA_IDLE: assert property (
    ce_i && !rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
  AST_RESET_STATE: assert property (
    $fell(srst_i) && $past(ce_i) |-> !receive_service_flag_o &&
    transmit_service_flag_o && interrupt_request_low_o && !irq_o)
    else $error("state after reset wrong");
  // Flags only move on a queue event of the right kind or a write
  AST_RX_RISE: assert property (
    $rose(receive_service_flag_o) && !$past(srst_i) |->
    $past(rx_push_i) || $past(wr_i)) else $error("rx flag rose alone");
  AST_RX_FALL: assert property (
    $fell(receive_service_flag_o) && !$past(srst_i) |->
    $past(rx_pop_i) || $past(wr_i)) else $error("rx flag fell alone");
  AST_TX_RISE: assert property (
    $rose(transmit_service_flag_o) && !$past(srst_i) |->
    $past(tx_pop_i) || $past(wr_i)) else $error("tx flag rose alone");
  AST_TX_FALL: assert property (
    $fell(transmit_service_flag_o) && !$past(srst_i) |->
    $past(tx_push_i) || $past(wr_i)) else $error("tx flag fell alone");
  // ==========================================================
  // Covers
  COV_RX_RISE: cover property ($rose(receive_service_flag_o));
  COV_TX_FALL: cover property ($fell(transmit_service_flag_o));
  COV_IRQ: cover property (irq_o && !interrupt_request_low_o);
endmodule

bind fifo_service_request_flags fifo_service_checker u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_push_i(rx_push_i),
  .rx_pop_i(rx_pop_i), .tx_push_i(tx_push_i), .tx_pop_i(tx_pop_i),
  .receive_service_flag_o(receive_service_flag_o),
  .transmit_service_flag_o(transmit_service_flag_o),
  .rx_arb_req_o(rx_arb_req_o), .tx_arb_req_o(tx_arb_req_o),
  .interrupt_request_low_o(interrupt_request_low_o),
  .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o),
  .irq_o(irq_o));

/* verification/fifo_service_request_flags_tb.sv */
// Self-checking bench of the FIFO service flags
`timescale 1ns/10ps
`include "fifo_service_map.vh"
module fifo_service_request_flags_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] ev = 4'h0; // tx_pop, tx_push, rx_pop, rx_push
  logic rx_en = 1'b0;
  logic tx_en = 1'b0;
  logic slow = 1'b0;
  wire [7:0] rdata_o;
  wire rx_f, tx_f, rx_arb, tx_arb, irq_low, rx_dma, tx_dma, irq;
  wire d_rx_pop, d_tx_push;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] rv;
  // Rows: trigger code, characters pushed into both queues, flags
  logic [1:0] r_code [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  int r_n [8] = '{0, 1, 127, 128, 191, 192, 255, 256};
  logic r_rx [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  logic r_tx [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  always #2.5 clk_i = ~clk_i;

  fifo_service_request_flags dut (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_push_i(ev[0]), .rx_pop_i(ev[1] | d_rx_pop),
    .tx_push_i(ev[2] | d_tx_push), .tx_pop_i(ev[3]),
    .receive_service_flag_o(rx_f), .transmit_service_flag_o(tx_f),
    .rx_arb_req_o(rx_arb), .tx_arb_req_o(tx_arb),
    .interrupt_request_low_o(irq_low), .rx_dma_req_o(rx_dma),
    .tx_dma_req_o(tx_dma), .irq_o(irq));

  dma_partner dma (
    .clk_i(clk_i), .srst_i(srst_i), .rx_en_i(rx_en), .tx_en_i(tx_en),
    .slow_i(slow), .rx_dma_req_i(rx_dma), .tx_dma_req_i(tx_dma),
    .rx_pop_o(d_rx_pop), .tx_push_o(d_tx_push));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp,
                     input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic pulse(input logic [3:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      ev <= m;
    end
    @(posedge clk_i);
    ev <= 4'h0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask

  // Same trigger code on both queues, all requests routed out
  task automatic cfg(input logic [1:0] c);
    wr(`FSR_OFF_MODE_ZERO, {2'h0, c, 4'h0});
    wr(`FSR_OFF_MODE_TWO, {4'h0, c, 2'h0});
    wr(`FSR_OFF_ISR, 8'h03);
    wr(`FSR_OFF_PIN_CFG, 8'h03);
  endtask

  // Hang guard; the run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    @(posedge clk_i);
    #1;
    chk({8'h00, rx_f}, 9'h000, "reset rx flag");
    chk({8'h00, tx_f}, 9'h001, "reset tx flag");
    chk({7'h00, irq_low, irq}, 9'h002, "reset pins");
    rd(`FSR_OFF_ISR, rv);
    chk({1'b0, rv}, 9'h001, "reset source");
    rd(8'h7f, rv);
    chk({1'b0, rv}, 9'h000, "unmapped read");
    wr(`FSR_OFF_RX_FILL, 8'h55);
    rd(`FSR_OFF_RX_FILL, rv);
    chk({1'b0, rv}, 9'h000, "fill is read only");
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      do_reset();
      cfg(r_code[i]);
      pulse(4'h5, r_n[i]);
      chk({8'h00, rx_f}, {8'h00, r_rx[i]}, "row rx");
      chk({8'h00, tx_f}, {8'h00, r_tx[i]}, "row tx");
      chk({8'h00, irq_low}, 9'h000, "row pin");
      chk({7'h00, rx_dma, tx_dma}, {7'h00, r_rx[i], r_tx[i]}, "dma");
      rd(`FSR_OFF_ISR, rv);
      chk({1'b0, rv}, {7'h00, r_rx[i], r_tx[i]}, "row source");
      $display("row %0d done", i);
    end
    // Last character out clears the ready flag; extra pop is dropped
    do_reset();
    cfg(2'h0);
    pulse(4'h1, 2);
    pulse(4'h2, 1);
    chk({8'h00, rx_f}, 9'h001, "one left");
    pulse(4'h2, 2);
    chk({7'h00, rx_f, rx_arb}, 9'h000, "empty");
    $display("drain test done");
    // Push into a full queue is dropped; after a pop, a new push sets the flag again
    do_reset();
    cfg(2'h3);
    pulse(4'h1, 257);
    chk({8'h00, rx_f}, 9'h001, "full");
    rd(`FSR_OFF_EVT_STATUS, rv);
    chk({1'b0, rv}, 9'h006, "events");
    chk({8'h00, irq}, 9'h000, "masked");
    wr(`FSR_OFF_EVT_MASK, 8'h04);
    chk({8'h00, irq}, 9'h001, "unmasked");
    wr(`FSR_OFF_EVT_STATUS, 8'h04);
    chk({8'h00, irq}, 9'h000, "cleared");
    pulse(4'h2, 1);
    chk({8'h00, rx_f}, 9'h000, "not full");
    pulse(4'h1, 1);
    chk({8'h00, rx_f}, 9'h001, "full again");
    $display("full test done");
    // DMA fills the transmit queue up to the half level
    do_reset();
    cfg(2'h1);
    @(posedge clk_i);
    tx_en <= 1'b1;
    for (int k = 0; k < 600 && tx_dma; k++) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    tx_en <= 1'b0;
    rd(`FSR_OFF_TX_FILL, rv);
    chk({1'b0, rv}, 9'h080, "tx filled");
    chk({8'h00, tx_f}, 9'h000, "tx off");
    chk({7'h00, tx_arb, rx_arb}, 9'h000, "tx arb off");
    pulse(4'h8, 1);
    chk({8'h00, tx_f}, 9'h001, "tx back on");
    chk({7'h00, tx_arb, irq_low}, 9'h002, "tx arb on");
    // Clearing the mask keeps a set flag out of arbitration
    wr(`FSR_OFF_ISR, 8'h00);
    chk({7'h00, tx_arb, irq_low}, 9'h001, "mask off");
    chk({8'h00, tx_f}, 9'h001, "flag kept");
    wr(`FSR_OFF_ISR, 8'h03);
    // Slow DMA drains the receive queue in ready mode
    wr(`FSR_OFF_MODE_TWO, 8'h00);
    pulse(4'h1, 5);
    @(posedge clk_i);
    slow <= 1'b1;
    rx_en <= 1'b1;
    for (int k = 0; k < 100 && rx_f; k++) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    rx_en <= 1'b0;
    rd(`FSR_OFF_RX_FILL, rv);
    chk({1'b0, rv}, 9'h000, "rx drained");
    // Level override gives a threshold of three
    wr(`FSR_OFF_RX_LEVEL, 8'h03);
    pulse(4'h1, 2);
    chk({8'h00, rx_f}, 9'h000, "below level");
    pulse(4'h1, 1);
    chk({8'h00, rx_f}, 9'h001, "at level");
    $display("dma test done");
    end_of_test();
  end
endmodule
